// file: core/mode_panel_pkg.sv
// Package with constants, types and register map of the mode selector and status panel.
package mode_panel_pkg;
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned DEBOUNCE_NS     = 10_000_000;
    localparam int unsigned FLASH_HALF_NS   = 250_000_000;
    localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_NS / 10;
    localparam int unsigned FLASH_HALF_CYC  = FLASH_HALF_NS / 10;

    localparam int unsigned BAR_W           = 8;
    localparam int unsigned CNT_W           = 32;

    localparam logic [7:0] BAR_RESET        = 8'h00;
    localparam logic [7:0] RED_LEVEL_RESET  = 8'h40;
    localparam logic [7:0] ORG_LEVEL_RESET  = 8'h80;

    localparam logic [3:0] ADDR_CTRL        = 4'h0;
    localparam logic [3:0] ADDR_STATUS      = 4'h1;
    localparam logic [3:0] ADDR_IRQ_STAT    = 4'h2;
    localparam logic [3:0] ADDR_IRQ_MASK    = 4'h3;
    localparam logic [3:0] ADDR_LEVELS      = 4'h4;
    localparam logic [3:0] ADDR_LOSS_CNT    = 4'h5;

    localparam int unsigned CTRL_INIT_DONE  = 0;
    localparam int unsigned CTRL_DEV_ERROR  = 1;
    localparam int unsigned CTRL_LASER_BAD  = 2;
    localparam int unsigned CTRL_RESTART    = 3;

    localparam int unsigned IRQ_W           = 3;
    localparam int unsigned IRQ_MODE        = 0;
    localparam int unsigned IRQ_LOSS        = 1;
    localparam int unsigned IRQ_WARN        = 2;

    typedef enum logic [4:0] {
        MODE_AUTO    = 5'h01,
        MODE_MANUAL  = 5'h02,
        MODE_ADJUST  = 5'h04,
        MODE_LASER   = 5'h08,
        MODE_MONITOR = 5'h10
    } mode_e;

    typedef enum logic [3:0] {
        POWER_INIT  = 4'h1,
        POWER_READY = 4'h2,
        POWER_WARN  = 4'h4,
        POWER_ERROR = 4'h8
    } power_e;

    typedef struct packed {
        logic automatic_mode;
        logic manual_mode;
        logic adjust_mode;
        logic alignment_laser_mode;
        logic monitor_green;
        logic monitor_red;
        logic power_green;
        logic power_red;
    } leds_s;

    typedef struct packed {
        logic       link_up;
        logic       forward_en;
        logic       laser_on;
        logic       switching_output_one;
        logic [7:0] bar_level;
    } link_out_s;

    typedef struct packed {
        mode_e      mode;
        logic [2:0] key_sync;
        logic       key_stable;
        logic [CNT_W-1:0] deb_cnt;
        logic [CNT_W-1:0] flash_cnt;
        logic       flash_ph;
        logic       loss_flag;
        logic       link_prev;
        logic       warn_prev;
        logic [3:0] ctrl;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic [7:0] red_level;
        logic [7:0] org_level;
        logic [15:0] loss_cnt;
        logic       ack;
        logic [31:0] rdata;
        logic       irq;
        leds_s      leds;
        link_out_s  lnk;
    } state_s;
endpackage

// file: core/mode_panel.sv
// Mode selector, mode LEDs, link drop thresholds and power status LED of the optical link.
`timescale 1ns/1ps
// How it works
// - Every debounced selector press moves the device to another operating mode.
// - Exactly the LED of the active mode is lit.
// - Automatic mode lights its LED green and forwards data normally.
// - Automatic mode keeps link until received level falls below orange threshold.
// - Manual mode lights green, link held until level falls below green threshold.
// - Adjust mode lights green, link held until level falls below orange threshold.
// - Adjust mode blocks user data forwarding in both directions.
// - Adjust mode shows the peer's reported level on the local bar.
// - Alignment laser mode switches the mounting laser on and lights its LED.
// - Monitor LED off when inactive, green while no link loss seen.
// - First link loss in monitoring sets sticky flag shown red until restart.
// - During initialization the power LED flashes green and data is blocked.
// - After initialization the power LED is steady green.
// - Power LED flashes red on weak level, link loss or bad laser.
// - Device error shows steady red and overrides warning and normal states.
// - Switching output asserts while the level shows only red and orange.
module mode_panel #(
    parameter int unsigned DEBOUNCE_CYCLES = mode_panel_pkg::DEBOUNCE_CYC,
    parameter int unsigned FLASH_CYCLES    = mode_panel_pkg::FLASH_HALF_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic        ce_i,
    input  wire logic        mode_key_i,
    input  wire logic [7:0]  local_level_i,
    input  wire logic [7:0]  peer_level_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o,
    output mode_panel_pkg::leds_s     leds_o,
    output mode_panel_pkg::link_out_s link_o
);
    // A count of zero would make the debounce and flash comparisons wrap around.
    if (DEBOUNCE_CYCLES < 1 || FLASH_CYCLES < 1) begin : g_bad_counts
        $error("Counts must be at least one cycle.");
    end

    localparam int unsigned CNT_W = mode_panel_pkg::CNT_W;
    localparam int unsigned IRQ_W = mode_panel_pkg::IRQ_W;

    mode_panel_pkg::state_s q, d;

    function automatic mode_panel_pkg::mode_e next_mode(input mode_panel_pkg::mode_e m);
        case (m)
            mode_panel_pkg::MODE_AUTO:   next_mode = mode_panel_pkg::MODE_MANUAL;
            mode_panel_pkg::MODE_MANUAL: next_mode = mode_panel_pkg::MODE_ADJUST;
            mode_panel_pkg::MODE_ADJUST: next_mode = mode_panel_pkg::MODE_LASER;
            mode_panel_pkg::MODE_LASER:  next_mode = mode_panel_pkg::MODE_MONITOR;
            default:                     next_mode = mode_panel_pkg::MODE_AUTO;
        endcase
    endfunction

    function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [7:0] nw,
                                           input logic en);
        wr_byte = en ? nw : old;
    endfunction

    logic        press;
    logic        bus_req;
    logic        wr;
    logic [3:0]  idx;
    logic [7:0]  bar;
    logic [7:0]  thr;
    logic        link_now;
    logic        link_fall;
    logic        warn;
    logic [IRQ_W-1:0] ev;
    mode_panel_pkg::power_e power_state;

    always_comb begin
        d         = q;
        press     = 1'b0;
        ev        = '0;
        bus_req   = wb_cyc_i && wb_stb_i && !q.ack;
        wr        = bus_req && wb_we_i;
        idx       = wb_adr_i[5:2];

        // Selector key: the input is synchronised, then must stay steady to count.
        d.key_sync = {q.key_sync[1:0], mode_key_i};
        if (q.key_sync[2] == q.key_stable) begin
            d.deb_cnt = '0;
        end else if (q.deb_cnt >= CNT_W'(DEBOUNCE_CYCLES - 1)) begin
            d.deb_cnt    = '0;
            d.key_stable = q.key_sync[2];
            press        = q.key_sync[2];
        end else begin
            d.deb_cnt = q.deb_cnt + CNT_W'(1);
        end

        if (press) begin
            d.mode = next_mode(q.mode);
            ev[mode_panel_pkg::IRQ_MODE] = 1'b1;
        end

        // Shared flash timer for both flashing power LED patterns.
        if (q.flash_cnt >= CNT_W'(FLASH_CYCLES - 1)) begin
            d.flash_cnt = '0;
            d.flash_ph  = !q.flash_ph;
        end else begin
            d.flash_cnt = q.flash_cnt + CNT_W'(1);
        end

        // Level shown on the bar comes from the peer while adjusting.
        bar = (q.mode == mode_panel_pkg::MODE_ADJUST) ? peer_level_i : local_level_i;
        // Manual mode drops at the green boundary, the others at the orange one.
        thr = (q.mode == mode_panel_pkg::MODE_MANUAL) ? q.org_level : q.red_level;
        link_now  = (local_level_i >= thr) && q.ctrl[mode_panel_pkg::CTRL_INIT_DONE];
        link_fall = q.link_prev && !link_now;
        d.link_prev = link_now;

        // Monitoring: a set from a loss wins over a restart in the same cycle.
        if (press && next_mode(q.mode) == mode_panel_pkg::MODE_MONITOR)
            d.loss_flag = 1'b0;
        if (wr && idx == mode_panel_pkg::ADDR_CTRL && wb_sel_i[0]
            && wb_dat_i[mode_panel_pkg::CTRL_RESTART])
            d.loss_flag = 1'b0;
        if (q.mode == mode_panel_pkg::MODE_MONITOR && link_fall) begin
            d.loss_flag = 1'b1;
            d.loss_cnt  = q.loss_cnt + 16'h0001;
        end
        if (link_fall)
            ev[mode_panel_pkg::IRQ_LOSS] = 1'b1;

        // Weak level means the local level has fallen into red, not merely out of green.
        warn = (local_level_i < q.red_level) || !link_now
               || q.ctrl[mode_panel_pkg::CTRL_LASER_BAD];
        d.warn_prev = warn;
        if (warn && !q.warn_prev)
            ev[mode_panel_pkg::IRQ_WARN] = 1'b1;

        if (q.ctrl[mode_panel_pkg::CTRL_DEV_ERROR])
            power_state = mode_panel_pkg::POWER_ERROR;
        else if (!q.ctrl[mode_panel_pkg::CTRL_INIT_DONE])
            power_state = mode_panel_pkg::POWER_INIT;
        else if (warn)
            power_state = mode_panel_pkg::POWER_WARN;
        else
            power_state = mode_panel_pkg::POWER_READY;

        case (power_state)
            mode_panel_pkg::POWER_INIT: begin
                d.leds.power_green = q.flash_ph;
                d.leds.power_red   = 1'b0;
            end
            mode_panel_pkg::POWER_READY: begin
                d.leds.power_green = 1'b1;
                d.leds.power_red   = 1'b0;
            end
            mode_panel_pkg::POWER_WARN: begin
                d.leds.power_green = 1'b0;
                d.leds.power_red   = q.flash_ph;
            end
            default: begin
                d.leds.power_green = 1'b0;
                d.leds.power_red   = 1'b1;
            end
        endcase

        // Mode LEDs follow the mode register so that exactly one is lit.
        d.leds.automatic_mode       = (d.mode == mode_panel_pkg::MODE_AUTO);
        d.leds.manual_mode          = (d.mode == mode_panel_pkg::MODE_MANUAL);
        d.leds.adjust_mode          = (d.mode == mode_panel_pkg::MODE_ADJUST);
        d.leds.alignment_laser_mode = (d.mode == mode_panel_pkg::MODE_LASER);
        d.leds.monitor_green = (d.mode == mode_panel_pkg::MODE_MONITOR) && !d.loss_flag;
        d.leds.monitor_red   = (d.mode == mode_panel_pkg::MODE_MONITOR) && d.loss_flag;

        d.lnk.link_up    = link_now;
        // Forwarding needs finished init and any mode but adjust.
        d.lnk.forward_en = link_now && q.ctrl[mode_panel_pkg::CTRL_INIT_DONE]
                           && (q.mode != mode_panel_pkg::MODE_ADJUST);
        d.lnk.laser_on   = (d.mode == mode_panel_pkg::MODE_LASER);
        d.lnk.switching_output_one = (local_level_i < q.org_level);
        d.lnk.bar_level  = bar;

        // Register bus: one wait-free answer per request, ack drops next cycle.
        d.ack   = bus_req;
        d.rdata = '0;
        if (wr) begin
            case (idx)
                mode_panel_pkg::ADDR_CTRL: begin
                    d.ctrl = wb_sel_i[0] ? wb_dat_i[3:0] : q.ctrl;
                    d.ctrl[mode_panel_pkg::CTRL_RESTART] = 1'b0;
                end
                mode_panel_pkg::ADDR_IRQ_STAT:
                    if (wb_sel_i[0])
                        d.irq_stat = q.irq_stat & ~wb_dat_i[IRQ_W-1:0];
                mode_panel_pkg::ADDR_IRQ_MASK:
                    if (wb_sel_i[0])
                        d.irq_mask = wb_dat_i[IRQ_W-1:0];
                mode_panel_pkg::ADDR_LEVELS: begin
                    d.red_level = wr_byte(q.red_level, wb_dat_i[7:0], wb_sel_i[0]);
                    d.org_level = wr_byte(q.org_level, wb_dat_i[15:8], wb_sel_i[1]);
                end
                mode_panel_pkg::ADDR_LOSS_CNT:
                    d.loss_cnt = '0;
                default: ;
            endcase
        end else if (bus_req) begin
            case (idx)
                mode_panel_pkg::ADDR_CTRL:     d.rdata = {28'h0, q.ctrl};
                mode_panel_pkg::ADDR_STATUS:   d.rdata = {16'h0, q.lnk.bar_level,
                                                          q.loss_flag, q.lnk.link_up,
                                                          1'b0, q.mode};
                mode_panel_pkg::ADDR_IRQ_STAT: d.rdata = {29'h0, q.irq_stat};
                mode_panel_pkg::ADDR_IRQ_MASK: d.rdata = {29'h0, q.irq_mask};
                mode_panel_pkg::ADDR_LEVELS:   d.rdata = {16'h0, q.org_level, q.red_level};
                mode_panel_pkg::ADDR_LOSS_CNT: d.rdata = {16'h0, q.loss_cnt};
                default:                       d.rdata = '0;
            endcase
        end
        // New events are applied after the clear so that a set wins.
        d.irq_stat = d.irq_stat | ev;
        d.irq      = |(d.irq_stat & q.irq_mask);
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q           <= '0;
            q.mode      <= mode_panel_pkg::MODE_AUTO;
            q.red_level <= mode_panel_pkg::RED_LEVEL_RESET;
            q.org_level <= mode_panel_pkg::ORG_LEVEL_RESET;
            // The link is down during init, so a clear history would fake a warning edge.
            q.warn_prev <= 1'b1;
            q.leds.automatic_mode <= 1'b1;
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign wb_dat_o = q.rdata;
    assign wb_ack_o = q.ack;
    assign irq_o    = q.irq;
    assign leds_o   = q.leds;
    assign link_o   = q.lnk;
endmodule

// file: sim/mode_panel_sva.sv
// Port-level checks of the mode panel.
`timescale 1ns/1ps
module mode_panel_sva #(
    parameter int unsigned DEBOUNCE_CYCLES = 4,
    parameter int unsigned FLASH_CYCLES    = 4,
    parameter logic [7:0]  ORG_LEVEL       = mode_panel_pkg::ORG_LEVEL_RESET
) (
    input wire logic                      clk_i,
    input wire logic                      nrst_i,
    input wire logic                      ce_i,
    input wire logic                      mode_key_i,
    input wire logic [7:0]                local_level_i,
    input wire logic [7:0]                peer_level_i,
    input wire logic                      wb_cyc_i,
    input wire logic                      wb_stb_i,
    input wire logic                      wb_ack_o,
    input wire mode_panel_pkg::leds_s     leds_o,
    input wire mode_panel_pkg::link_out_s link_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    logic [3:0] mode_leds;
    assign mode_leds = {leds_o.automatic_mode, leds_o.manual_mode,
                        leds_o.adjust_mode, leds_o.alignment_laser_mode};
    sequence taken_s;
        ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence ack_pulse_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_ack_one_cycle: assert property (taken_s |=> ack_pulse_s)
        else $error("bus ack missing or too long");
    a_one_mode_led: assert property (
        $onehot({mode_leds, leds_o.monitor_green | leds_o.monitor_red}))
        else $error("mode LEDs not one-hot");
    a_adjust_no_fwd: assert property (leds_o.adjust_mode [*2] |-> !link_o.forward_en)
        else $error("data forwarded in adjust mode");
    a_adjust_peer_bar: assert property (
        leds_o.adjust_mode [*2] |-> link_o.bar_level == $past(peer_level_i))
        else $error("bar does not show peer level");
    a_laser_follows: assert property (leds_o.alignment_laser_mode [*2] |-> link_o.laser_on)
        else $error("alignment laser off");
    // The output is registered one edge behind, so only a running edge is judged.
    a_switch_output: assert property (
        ce_i && nrst_i && $stable(local_level_i)
        |=> link_o.switching_output_one == ($past(local_level_i) < ORG_LEVEL))
        else $error("switching output wrong");
    a_no_link_fwd: assert property (!link_o.link_up |-> !link_o.forward_en)
        else $error("forwarding without link");
    a_mode_needs_key: assert property ($changed(mode_leds) |-> $past(mode_key_i, 2))
        else $error("mode changed without key");
    a_power_one_color: assert property (!(leds_o.power_green && leds_o.power_red))
        else $error("power LED both colors");
endmodule

bind mode_panel mode_panel_sva #(
    .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
    .FLASH_CYCLES   (FLASH_CYCLES)
) u_sva (
    .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .mode_key_i(mode_key_i),
    .local_level_i(local_level_i), .peer_level_i(peer_level_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .leds_o(leds_o), .link_o(link_o)
);

// file: sim/panel_operator.sv
// Operator at the selector key and peer transceiver levels.
`timescale 1ns/1ps
module panel_operator (
    input  wire logic  clk_i,
    output logic       mode_key_o,
    output logic [7:0] local_level_o,
    output logic [7:0] peer_level_o
);
    initial begin
        mode_key_o = 1'b0;
        local_level_o = 8'h00;
        peer_level_o = 8'h00;
    end
    // Held well past debounce and sync so one press is one step.
    task automatic press();
        @(posedge clk_i);
        mode_key_o <= 1'b1;
        repeat (12) @(posedge clk_i);
        mode_key_o <= 1'b0;
        repeat (12) @(posedge clk_i);
    endtask
    task automatic levels(input logic [7:0] loc, input logic [7:0] peer);
        @(posedge clk_i);
        local_level_o <= loc;
        peer_level_o <= peer;
    endtask
endmodule

// file: sim/tb.sv
// Self-checking bench of the mode panel over its register bus.
`timescale 1ns/1ps
module tb;
    logic                      clk_i = 1'b0;
    logic                      nrst_i = 1'b0;
    logic                      ce = 1'b0;
    logic                      wb_cyc = 1'b0;
    logic                      wb_stb = 1'b0;
    logic                      wb_we = 1'b0;
    logic [5:0]                wb_adr = 6'h00;
    logic [31:0]               wb_dat = 32'h0;
    logic [31:0]               dat_o;
    logic [31:0]               rd;
    logic                      ack;
    logic                      irq;
    logic                      key;
    logic [7:0]                loc;
    logic [7:0]                peer;
    mode_panel_pkg::leds_s     leds;
    mode_panel_pkg::link_out_s lnk;
    int                        fails = 0;
    int                        comparisons = 0;

    always #5 clk_i = ~clk_i;

    mode_panel #(.DEBOUNCE_CYCLES(4), .FLASH_CYCLES(4)) u_mode_panel (
        .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce), .mode_key_i(key),
        .local_level_i(loc), .peer_level_i(peer), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf),
        .wb_dat_i(wb_dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .irq_o(irq),
        .leds_o(leds), .link_o(lnk));
    panel_operator u_panel_operator (
        .clk_i(clk_i), .mode_key_o(key), .local_level_o(loc), .peer_level_o(peer));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [3:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= {idx, 2'b00};
        wb_dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) fails++;
        rd = dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask
    task automatic status(input logic [15:0] exp);
        wb(1'b0, 4'h1, 32'h0);
        chk(32'(rd[15:0] & 16'hffdf), 32'(exp));
    endtask
    // Watches one LED bit long enough to see both flash phases.
    task automatic watch(input int b, input logic [1:0] exp);
        logic hi;
        logic lo;
        hi = 1'b0;
        lo = 1'b1;
        repeat (12) begin
            @(negedge clk_i);
            hi |= leds[b];
            lo &= leds[b];
        end
        chk(32'({hi, lo}), 32'(exp));
    endtask
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk_i);
        fails++;
        finish_test();
    end

    initial begin
        repeat (16) @(posedge clk_i);
        nrst_i <= 1'b1;
        watch(1, 2'b00);
        @(posedge clk_i);
        ce <= 1'b1;
        watch(1, 2'b10);
        wb(1'b0, 4'h4, 32'h0);
        chk(rd, 32'h0000_8040);
        wb(1'b0, 4'hf, 32'h0);
        chk(rd, 32'h0);
        u_panel_operator.levels(8'hc0, 8'h00);
        wb(1'b1, 4'h0, 32'h1);
        watch(1, 2'b11);
        status(16'hc041);
        chk(32'(lnk.forward_en), 32'h1);
        u_panel_operator.levels(8'h60, 8'h33);
        status(16'h6041);
        chk(32'(lnk.switching_output_one), 32'h1);
        watch(0, 2'b00);
        u_panel_operator.levels(8'h30, 8'h33);
        watch(0, 2'b10);
        chk(32'(lnk.link_up), 32'h0);
        u_panel_operator.levels(8'h60, 8'h33);
        wb(1'b1, 4'h3, 32'h1);
        u_panel_operator.press();
        status(16'h6002);
        watch(6, 2'b11);
        chk(32'(irq), 32'h1);
        wb(1'b1, 4'h2, 32'h7);
        repeat (2) @(negedge clk_i);
        chk(32'(irq), 32'h0);
        u_panel_operator.press();
        status(16'h3344);
        chk(32'(lnk.forward_en), 32'h0);
        u_panel_operator.press();
        chk(32'(lnk.laser_on), 32'h1);
        status(16'h6048);
        u_panel_operator.levels(8'hc0, 8'h00);
        u_panel_operator.press();
        watch(3, 2'b11);
        u_panel_operator.levels(8'h10, 8'h00);
        u_panel_operator.levels(8'hc0, 8'h00);
        watch(2, 2'b11);
        status(16'hc0d0);
        wb(1'b1, 4'h0, 32'h9);
        watch(3, 2'b11);
        u_panel_operator.levels(8'h10, 8'h00);
        u_panel_operator.levels(8'hc0, 8'h00);
        wb(1'b0, 4'h5, 32'h0);
        chk(rd, 32'h0000_0002);
        u_panel_operator.press();
        status(16'hc0c1);
        repeat (4) u_panel_operator.press();
        watch(3, 2'b11);
        u_panel_operator.levels(8'h60, 8'h00);
        wb(1'b1, 4'h0, 32'h3);
        watch(0, 2'b11);
        watch(1, 2'b00);
        finish_test();
    end
endmodule
